// ### core/cfg_fwd_bridge.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] claim type 1 for translation only with ad[1:0]=01 and config read/write
// [R2] translation also needs bus field equal to the secondary bus number
// [R3] type 0 cycles appear only on the secondary side, never upstream
// [R4] translated type 0 address has ad[1:0] forced to 00
// [R5] translated ad[15:11] is zero; function and register fields pass through
// [R6] device 0 to 15 drives one-hot ad[31:16], bit 16 plus device number
// [R7] device 16 to 30 drives ad[31:16] zero yet still forwards the cycle
// [R8] device 31 with register 0 makes a special cycle, else upper bits zero; the code also requires function 7 and a config write
// [R9] a translated cycle with no address line selected ends in master abort
// [R10] translated reads and writes are delayed, one 32-bit data phase only
// [R11] type 1 for a bus below secondary is forwarded down unchanged
// [R12] downstream forwarding needs secondary < bus <= subordinate
// [R13] upstream forwarding: config write, 01, device 11111, function 111
// [R14] upstream forwarding needs bus outside secondary..subordinate inclusive
// [R15] forwarded type 1 writes are delayed, one data phase only
// [R16] devices above 15 on the secondary bus need outside select logic
// [R17] type 0 cycles started on the secondary bus are never answered
// [R18] special cycle conversion changes only the command code
// [R19] repeats of a pending forwarded cycle are answered with retry
module cfg_fwd_bridge
    import cfg_fwd_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // bus numbers from configuration space
    input wire logic [cfg_fwd_pkg::BUS_W-1:0] i_pri_bus_num,
    input wire logic [cfg_fwd_pkg::BUS_W-1:0] i_sec_bus_num,
    input wire logic [cfg_fwd_pkg::BUS_W-1:0] i_sub_bus_num,
    // primary target side
    input wire logic i_p_addr_valid,
    input wire logic [cfg_fwd_pkg::ADDR_W-1:0] i_p_addr,
    input wire logic [cfg_fwd_pkg::CMD_W-1:0] i_p_cmd,
    input wire logic [cfg_fwd_pkg::ADDR_W-1:0] i_p_wdata,
    input wire logic i_p_multi,
    output logic o_p_claim,
    output logic o_p_retry,
    output logic o_p_trdy,
    output logic o_p_stop,
    output logic o_p_mabort,
    output logic [cfg_fwd_pkg::ADDR_W-1:0] o_p_rdata,
    // secondary target side
    input wire logic i_s_addr_valid,
    input wire logic [cfg_fwd_pkg::ADDR_W-1:0] i_s_addr,
    input wire logic [cfg_fwd_pkg::CMD_W-1:0] i_s_cmd,
    input wire logic [cfg_fwd_pkg::ADDR_W-1:0] i_s_wdata,
    input wire logic i_s_multi,
    output logic o_s_claim,
    output logic o_s_retry,
    output logic o_s_trdy,
    output logic o_s_stop,
    output logic o_s_mabort,
    // secondary master side (downstream)
    output logic o_s_mst_valid,
    output logic [cfg_fwd_pkg::ADDR_W-1:0] o_s_mst_addr,
    output logic [cfg_fwd_pkg::CMD_W-1:0] o_s_mst_cmd,
    output logic [cfg_fwd_pkg::ADDR_W-1:0] o_s_mst_data,
    output logic o_s_mst_no_idsel,
    input wire logic i_s_mst_done,
    input wire logic i_s_mst_mabort,
    input wire logic [cfg_fwd_pkg::ADDR_W-1:0] i_s_mst_rdata,
    // primary master side (upstream)
    output logic o_p_mst_valid,
    output logic [cfg_fwd_pkg::ADDR_W-1:0] o_p_mst_addr,
    output logic [cfg_fwd_pkg::CMD_W-1:0] o_p_mst_cmd,
    output logic [cfg_fwd_pkg::ADDR_W-1:0] o_p_mst_data,
    input wire logic i_p_mst_done,
    input wire logic i_p_mst_mabort
);
    import cfg_fwd_pkg::*;

    // ==========================================================
    // address phase decode, one decoder per side
    logic p_fwd, p_type0, p_special, p_no_idsel;
    logic s_fwd, s_special;
    logic [31:0] p_dec_addr, s_dec_addr;
    logic [3:0] p_dec_cmd, s_dec_cmd;

    cfg_fwd_decode u_p_decode (
        .i_addr(i_p_addr),
        .i_cmd(i_p_cmd),
        .i_from_sec(1'b0),
        .i_pri_bus_num(i_pri_bus_num),
        .i_sec_bus_num(i_sec_bus_num),
        .i_sub_bus_num(i_sub_bus_num),
        .o_fwd(p_fwd),
        .o_type0(p_type0),
        .o_special(p_special),
        .o_no_idsel(p_no_idsel),
        .o_addr(p_dec_addr),
        .o_cmd(p_dec_cmd)
    );

    cfg_fwd_decode u_s_decode (
        .i_addr(i_s_addr),
        .i_cmd(i_s_cmd),
        .i_from_sec(1'b1),
        .i_pri_bus_num(i_pri_bus_num),
        .i_sec_bus_num(i_sec_bus_num),
        .i_sub_bus_num(i_sub_bus_num),
        .o_fwd(s_fwd),
        .o_type0(),
        .o_special(s_special),
        .o_no_idsel(),
        .o_addr(s_dec_addr),
        .o_cmd(s_dec_cmd)
    );

    // ==========================================================
    // delayed transaction slot
    fwd_state_t state_reg, state_next;
    logic src_sec_reg;
    logic special_reg;
    logic no_idsel_reg;
    logic mabort_reg;
    logic [31:0] req_addr_reg, req_data_reg, out_addr_reg, rdata_reg;
    logic [3:0] req_cmd_reg, out_cmd_reg;

    // a repeat matches on address, command and, for writes, data
    function automatic logic same_req(input logic [31:0] a, input logic [3:0] c,
                                      input logic [31:0] d, input logic [31:0] ra,
                                      input logic [3:0] rc, input logic [31:0] rd);
        same_req = (a == ra) && (c == rc) && ((c == CMD_CFG_RD) || (d == rd));
    endfunction

    wire logic st_idle = (state_reg == ST_IDLE);
    wire logic st_issue = (state_reg == ST_ISSUE);
    wire logic st_done = (state_reg == ST_DONE);
    wire logic p_match = !src_sec_reg &&
        same_req(i_p_addr, i_p_cmd, i_p_wdata, req_addr_reg, req_cmd_reg, req_data_reg);
    wire logic s_match = src_sec_reg &&
        same_req(i_s_addr, i_s_cmd, i_s_wdata, req_addr_reg, req_cmd_reg, req_data_reg);
    wire logic p_claim = i_p_addr_valid && p_fwd;
    wire logic s_claim = i_s_addr_valid && s_fwd; // [R17]
    // the single slot serves the primary side first when both arrive together
    wire logic p_start = p_claim && st_idle;
    wire logic s_start = s_claim && st_idle && !p_claim;
    wire logic p_done = p_claim && st_done && p_match;
    wire logic s_done = s_claim && st_done && s_match;
    wire logic mst_done = st_issue && (src_sec_reg ? i_p_mst_done : i_s_mst_done);
    wire logic mst_mabort = src_sec_reg ? i_p_mst_mabort : i_s_mst_mabort;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (p_start || s_start) begin
                    state_next = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                if (mst_done) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                if (p_done || s_done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // capture the raw request for matching and the translated cycle for the master
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            src_sec_reg <= 1'b0;
            special_reg <= 1'b0;
            no_idsel_reg <= 1'b0;
            req_addr_reg <= WORD_RST;
            req_data_reg <= WORD_RST;
            req_cmd_reg <= CMD_RST;
            out_addr_reg <= WORD_RST;
            out_cmd_reg <= CMD_RST;
        end else if (p_start || s_start) begin
            src_sec_reg <= s_start;
            special_reg <= p_start ? p_special : s_special;
            no_idsel_reg <= p_start && p_no_idsel; // [R9]
            req_addr_reg <= p_start ? i_p_addr : i_s_addr;
            req_data_reg <= p_start ? i_p_wdata : i_s_wdata;
            req_cmd_reg <= p_start ? i_p_cmd : i_s_cmd;
            out_addr_reg <= p_start ? p_dec_addr : s_dec_addr; // [R4] [R5] [R6] [R7] [R11]
            out_cmd_reg <= p_start ? p_dec_cmd : s_dec_cmd; // [R8] [R18]
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            mabort_reg <= 1'b0;
            rdata_reg <= WORD_RST;
        end else if (mst_done) begin
            mabort_reg <= mst_mabort;
            rdata_reg <= i_s_mst_rdata;
        end
    end

    // ==========================================================
    // answers to the initiators
    // the first attempt and every repeat while pending end in retry
    assign o_p_claim = p_claim;
    assign o_p_retry = p_claim && !p_done; // [R19] [R10]
    assign o_p_trdy = p_done;
    assign o_p_stop = o_p_retry || (p_done && i_p_multi); // [R10] [R15]
    // master abort is the normal end of a special cycle and is not passed back
    assign o_p_mabort = p_done && mabort_reg && !special_reg;
    assign o_p_rdata = rdata_reg;
    assign o_s_claim = s_claim;
    assign o_s_retry = s_claim && !s_done; // [R19]
    assign o_s_trdy = s_done;
    assign o_s_stop = o_s_retry || (s_done && i_s_multi); // [R15]
    assign o_s_mabort = s_done && mabort_reg && !special_reg;

    // ==========================================================
    // master requests toward the target buses
    assign o_s_mst_valid = st_issue && !src_sec_reg;
    assign o_s_mst_addr = out_addr_reg;
    assign o_s_mst_cmd = out_cmd_reg;
    assign o_s_mst_data = req_data_reg;
    assign o_s_mst_no_idsel = no_idsel_reg;
    // upstream carries only forwarded type 1 addresses, never type 0
    assign o_p_mst_valid = st_issue && src_sec_reg; // [R3]
    assign o_p_mst_addr = out_addr_reg;
    assign o_p_mst_cmd = out_cmd_reg;
    assign o_p_mst_data = req_data_reg;

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    wire logic p_t0_start = p_start && p_type0;

    a_type0_claim_cond: assert property (p_t0_start |-> (i_p_addr[1:0] == TYPE1_CODE) && // [R1]
        (i_p_cmd == CMD_CFG_RD || i_p_cmd == CMD_CFG_WR))
        else $error("type 0 translation without a type 1 config cycle");
    a_type0_bus_match: assert property (p_t0_start |-> // [R2]
        i_p_addr[BUS_MSB:BUS_LSB] == i_sec_bus_num)
        else $error("type 0 translation for a foreign bus number");
    a_no_type0_up: assert property (o_p_mst_valid |-> // [R3]
        o_p_mst_addr[1:0] != TYPE0_CODE)
        else $error("type 0 cycle issued on the primary bus");
    a_type0_low_fields: assert property (p_t0_start |=> (o_s_mst_addr[1:0] == 2'h0) && // [R4] [R5]
        (o_s_mst_addr[DEV_MSB:DEV_LSB] == 5'h00) &&
        (o_s_mst_addr[FUNC_MSB:REG_LSB] == $past(i_p_addr[FUNC_MSB:REG_LSB])))
        else $error("translated low address fields wrong");
    a_idsel_onehot: assert property (p_t0_start && !i_p_addr[DEV_MSB] |=> // [R6]
        $onehot(o_s_mst_addr[IDSEL_MSB:IDSEL_LSB]) && !o_s_mst_no_idsel &&
        (o_s_mst_addr[IDSEL_MSB:IDSEL_LSB] == (16'h0001 << $past(i_p_addr[14:11]))))
        else $error("address select line not one-hot for device 0 to 15");
    a_idsel_high_dev: assert property (p_t0_start && i_p_addr[DEV_MSB] |=> // [R7] [R9]
        (o_s_mst_addr[IDSEL_MSB:IDSEL_LSB] == 16'h0000) && o_s_mst_no_idsel && o_s_mst_valid)
        else $error("high device number not forwarded with zero select");
    a_special_down: assert property (p_start && p_special |=> // [R8] [R18]
        (o_s_mst_cmd == CMD_SPECIAL) && (o_s_mst_addr == $past(i_p_addr)) &&
        (o_s_mst_data == $past(i_p_wdata)))
        else $error("special cycle conversion altered address or data");
    a_single_phase: assert property ((o_p_trdy && i_p_multi) |-> o_p_stop) // [R10] [R15]
        else $error("translated cycle allowed a second data phase");
    a_type1_passthru: assert property (p_start && !p_type0 && !p_special |=> // [R11] [R12]
        (o_s_mst_addr == $past(i_p_addr)) && (o_s_mst_cmd == $past(i_p_cmd)))
        else $error("downstream type 1 not forwarded unchanged");
    a_upstream_cond: assert property (s_start |-> (i_s_cmd == CMD_CFG_WR) && // [R13] [R14]
        (i_s_addr[1:0] == TYPE1_CODE) &&
        (i_s_addr[DEV_MSB:FUNC_LSB] == {DEV_BCAST, FUNC_ALL}) &&
        ((i_s_addr[BUS_MSB:BUS_LSB] < i_sec_bus_num) ||
        (i_s_addr[BUS_MSB:BUS_LSB] > i_sub_bus_num)))
        else $error("upstream forwarding outside its conditions");
    a_sec_type0_ignored: assert property (i_s_addr_valid && // [R17]
        (i_s_addr[1:0] == TYPE0_CODE) |-> !o_s_claim && !o_s_retry && !o_s_trdy)
        else $error("answered a type 0 cycle from the secondary bus");
    a_pending_retry: assert property (st_issue && o_p_claim |-> o_p_retry && !o_p_trdy) // [R19]
        else $error("pending cycle not retried");
    a_issue_hold: assert property (o_s_mst_valid && !i_s_mst_done |=>
        o_s_mst_valid && $stable(o_s_mst_addr) && $stable(o_s_mst_cmd))
        else $error("downstream request dropped before completion");

    c_type0_xlate: cover property (p_t0_start ##[1:20] o_p_trdy);
    c_special_down: cover property (p_start && p_special ##[1:20] o_p_trdy);
    c_upstream_fwd: cover property (s_start ##[1:20] o_s_trdy);
    c_retry_pending: cover property (st_issue && o_p_retry);
endmodule // cfg_fwd_bridge
`default_nettype wire

// ### core/cfg_fwd_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// address phase decode and type 1 to type 0 translation
module cfg_fwd_decode
    import cfg_fwd_pkg::*;
(
    // address phase
    input wire logic [cfg_fwd_pkg::ADDR_W-1:0] i_addr,
    input wire logic [cfg_fwd_pkg::CMD_W-1:0] i_cmd,
    input wire logic i_from_sec,
    // bus numbers
    input wire logic [cfg_fwd_pkg::BUS_W-1:0] i_pri_bus_num,
    input wire logic [cfg_fwd_pkg::BUS_W-1:0] i_sec_bus_num,
    input wire logic [cfg_fwd_pkg::BUS_W-1:0] i_sub_bus_num,
    // decision and translated cycle
    output logic o_fwd,
    output logic o_type0,
    output logic o_special,
    output logic o_no_idsel,
    output logic [cfg_fwd_pkg::ADDR_W-1:0] o_addr,
    output logic [cfg_fwd_pkg::CMD_W-1:0] o_cmd
);
    wire logic [7:0] bus = i_addr[BUS_MSB:BUS_LSB];
    wire logic [4:0] dev = i_addr[DEV_MSB:DEV_LSB];
    wire logic [2:0] func = i_addr[FUNC_MSB:FUNC_LSB];
    wire logic [5:0] regn = i_addr[REG_MSB:REG_LSB];
    wire logic is_wr = (i_cmd == CMD_CFG_WR);
    wire logic is_cfg = is_wr || (i_cmd == CMD_CFG_RD);
    wire logic is_t1 = (i_addr[1:0] == TYPE1_CODE);
    wire logic bcast = (dev == DEV_BCAST) && (func == FUNC_ALL);
    wire logic below_sec = (bus > i_sec_bus_num) && (bus <= i_sub_bus_num); // [R12]
    wire logic outside = (bus < i_sec_bus_num) || (bus > i_sub_bus_num); // [R14]
    wire logic hit_t0 = !i_from_sec && is_t1 && is_cfg && (bus == i_sec_bus_num); // [R1] [R2]
    wire logic hit_dn = !i_from_sec && is_t1 && is_cfg && below_sec; // [R11]
    wire logic hit_up = i_from_sec && is_t1 && is_wr && bcast && outside; // [R13] [R14]
    // special cycle only for a broadcast write to register zero
    wire logic spec_dn = hit_t0 && is_wr && bcast && (regn == REG_SPECIAL); // [R8]
    wire logic spec_up = hit_up && (bus == i_pri_bus_num) && (regn == REG_SPECIAL);
    // devices above 15 get no address line; an outside circuit must select them
    wire logic [15:0] idsel = dev[4] ? 16'h0000 : (16'h0001 << dev[3:0]); // [R6] [R7]
    wire logic [31:0] t0_addr = {idsel, 5'h00, i_addr[FUNC_MSB:REG_LSB], TYPE0_CODE}; // [R4] [R5]

    assign o_special = spec_dn || spec_up;
    assign o_type0 = hit_t0 && !spec_dn;
    assign o_fwd = hit_t0 || hit_dn || hit_up;
    assign o_no_idsel = o_type0 && dev[4]; // [R9]
    // special cycles keep address and data, only the command changes
    assign o_addr = o_type0 ? t0_addr : i_addr; // [R18] [R3]
    assign o_cmd = o_special ? CMD_SPECIAL : i_cmd; // [R18]
endmodule // cfg_fwd_decode
`default_nettype wire

// ### inc/cfg_fwd_pkg.sv
`default_nettype none
// ==========================================================
// configuration forwarding constants
package cfg_fwd_pkg;
    localparam int ADDR_W = 32;
    localparam int BUS_W = 8;
    localparam int CMD_W = 4;
    localparam int IDSEL_W = 16;

    // bus commands
    localparam logic [3:0] CMD_CFG_RD = 4'ha;
    localparam logic [3:0] CMD_CFG_WR = 4'hb;
    localparam logic [3:0] CMD_SPECIAL = 4'h1;

    // address type codes in ad[1:0]
    localparam logic [1:0] TYPE0_CODE = 2'h0;
    localparam logic [1:0] TYPE1_CODE = 2'h1;

    // field positions of a type 1 address, and the type 0 select lines
    localparam int BUS_LSB = 16;
    localparam int BUS_MSB = 23;
    localparam int DEV_LSB = 11;
    localparam int DEV_MSB = 15;
    localparam int FUNC_LSB = 8;
    localparam int FUNC_MSB = 10;
    localparam int REG_LSB = 2;
    localparam int REG_MSB = 7;
    localparam int IDSEL_LSB = 16;
    localparam int IDSEL_MSB = 31;

    // broadcast device, function and register codes
    localparam logic [4:0] DEV_BCAST = 5'h1f;
    localparam logic [2:0] FUNC_ALL = 3'h7;
    localparam logic [5:0] REG_SPECIAL = 6'h00;

    // reset values
    localparam logic [31:0] WORD_RST = 32'h0;
    localparam logic [3:0] CMD_RST = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ISSUE = 3'b010,
        ST_DONE = 3'b100
    } fwd_state_t;
endpackage
`default_nettype wire

// ### testbench/cfg_fwd_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far side: targets behind the bridge's master engines
module cfg_fwd_far_model
    import cfg_fwd_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // answer delay in cycles, set by the bench
    input wire logic [3:0] i_lat,
    // cycle request from the bridge
    input wire logic i_valid,
    input wire logic [31:0] i_addr,
    input wire logic [3:0] i_cmd,
    input wire logic i_no_idsel,
    // answer
    output logic o_done,
    output logic o_mabort,
    output logic [31:0] o_rdata
);
    localparam logic [31:0] RD_KEY = 32'h5a5a_a5a5;
    logic [3:0] cnt_reg;
    logic served_reg;
    logic [31:0] pat_reg;
    // no select line, or a special cycle: nobody claims it
    wire logic nobody = i_no_idsel || (i_cmd == CMD_SPECIAL);
    // data lines are not held outside the answer cycle, so a late sample shows garbage
    assign o_rdata = o_done ? (i_addr ^ RD_KEY) : pat_reg;
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_reg <= 4'h0;
            served_reg <= 1'b0;
            o_done <= 1'b0;
            o_mabort <= 1'b0;
            pat_reg <= 32'h0000_0001;
        end else begin
            o_done <= 1'b0;
            o_mabort <= 1'b0;
            pat_reg <= {pat_reg[30:0], ~pat_reg[31]};
            if (!i_valid) begin
                cnt_reg <= 4'h0;
                served_reg <= 1'b0;
            end else if (!served_reg) begin
                if (cnt_reg == i_lat) begin
                    o_done <= 1'b1;
                    o_mabort <= nobody;
                    served_reg <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 4'h1;
                end
            end
        end
    end
endmodule // cfg_fwd_far_model
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench for the configuration forwarding bridge
module testbench;
    import cfg_fwd_pkg::*;
    logic i_ref_clk, i_reset, p_valid, s_valid, req_multi;
    logic [7:0] pri, sec, sub;
    logic [31:0] req_addr, req_wd, p_rdata, s_mst_addr, s_mst_data, p_mst_addr, p_mst_data;
    logic [31:0] s_rdata;
    logic [3:0] req_cmd, s_mst_cmd, p_mst_cmd, lat;
    logic p_claim, p_retry, p_trdy, p_stop, p_mab, s_claim, s_retry, s_trdy, s_stop, s_mab;
    logic s_mst_valid, s_noid, s_done, s_dmab, p_mst_valid, p_done, p_dmab;
    logic [4:0] ans;
    int bad_count, n_checks;

    // ==========================================================
    // design and far side
    cfg_fwd_bridge u_cfg_fwd_bridge (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_pri_bus_num(pri), .i_sec_bus_num(sec), .i_sub_bus_num(sub),
        .i_p_addr_valid(p_valid), .i_p_addr(req_addr), .i_p_cmd(req_cmd), .i_p_wdata(req_wd),
        .i_p_multi(req_multi), .o_p_claim(p_claim), .o_p_retry(p_retry), .o_p_trdy(p_trdy),
        .o_p_stop(p_stop), .o_p_mabort(p_mab), .o_p_rdata(p_rdata),
        .i_s_addr_valid(s_valid), .i_s_addr(req_addr), .i_s_cmd(req_cmd), .i_s_wdata(req_wd),
        .i_s_multi(req_multi), .o_s_claim(s_claim), .o_s_retry(s_retry), .o_s_trdy(s_trdy),
        .o_s_stop(s_stop), .o_s_mabort(s_mab),
        .o_s_mst_valid(s_mst_valid), .o_s_mst_addr(s_mst_addr), .o_s_mst_cmd(s_mst_cmd),
        .o_s_mst_data(s_mst_data), .o_s_mst_no_idsel(s_noid), .i_s_mst_done(s_done),
        .i_s_mst_mabort(s_dmab), .i_s_mst_rdata(s_rdata),
        .o_p_mst_valid(p_mst_valid), .o_p_mst_addr(p_mst_addr), .o_p_mst_cmd(p_mst_cmd),
        .o_p_mst_data(p_mst_data), .i_p_mst_done(p_done), .i_p_mst_mabort(p_dmab));
    cfg_fwd_far_model u_sec_far (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_lat(lat),
        .i_valid(s_mst_valid), .i_addr(s_mst_addr), .i_cmd(s_mst_cmd), .i_no_idsel(s_noid),
        .o_done(s_done), .o_mabort(s_dmab), .o_rdata(s_rdata));
    cfg_fwd_far_model u_pri_far (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_lat(lat),
        .i_valid(p_mst_valid), .i_addr(p_mst_addr), .i_cmd(p_mst_cmd), .i_no_idsel(1'b0),
        .o_done(p_done), .o_mabort(p_dmab), .o_rdata());

    initial begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end

    // ==========================================================
    // shared tasks
    function automatic logic [31:0] t1(logic [7:0] b, logic [4:0] d, logic [2:0] f, logic [5:0] r);
        return {8'h00, b, d, f, r, 2'b01};
    endfunction

    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // one address phase; answers are caught while the strobe is up
    task automatic strobe(input bit up, input logic [31:0] a, input logic [3:0] c, input bit m);
        @(negedge i_ref_clk);
        req_addr = a;
        req_cmd = c;
        req_wd = a ^ 32'hc0de_0000;
        req_multi = m;
        p_valid = !up;
        s_valid = up;
        #1;
        ans = up ? {s_claim, s_retry, s_trdy, s_stop, s_mab}
            : {p_claim, p_retry, p_trdy, p_stop, p_mab};
        @(negedge i_ref_clk);
        p_valid = 1'b0;
        s_valid = 1'b0;
    endtask

    task automatic wait_mst(input bit up, input bit lvl);
        int n;
        n = 0;
        while (((up ? p_mst_valid : s_mst_valid) !== lvl) && n < 200) begin
            @(negedge i_ref_clk);
            n++;
        end
        if (n == 200) begin
            bad_count++;
            $display("wrong value master request: expected %b, seen timeout", lvl);
            final_report();
        end
    endtask

    // full delayed transfer: attempt, forwarded cycle, repeat while pending when lat is above 4, completion
    task automatic xfer(input bit up, input logic [31:0] a, input logic [3:0] c,
                        input logic [31:0] ea, input logic [3:0] ec, input bit enoid,
                        input bit emab, input bit m);
        strobe(up, a, c, 1'b0);
        chk("first attempt", 32'(ans), 32'h1a);
        wait_mst(up, 1'b1);
        chk("cycle address", up ? p_mst_addr : s_mst_addr, ea);
        chk("cycle command", 32'(up ? p_mst_cmd : s_mst_cmd), 32'(ec));
        if (c == CMD_CFG_WR) chk("cycle data", up ? p_mst_data : s_mst_data,
            a ^ 32'hc0de_0000);
        if (!up && ec != CMD_SPECIAL) chk("no select flag", 32'(s_noid), 32'(enoid));
        if (lat > 4'h4) begin
            strobe(up, a, c, 1'b0);
            chk("pending repeat", 32'(ans), 32'h1a);
        end
        wait_mst(up, 1'b0);
        strobe(up, a, c, m);
        chk("completion", 32'(ans), 32'({3'b101, m, emab}));
        if (!up && c == CMD_CFG_RD && !emab) chk("read data", p_rdata,
            ea ^ 32'h5a5a_a5a5);
    endtask

    task automatic refuse(input bit up, input logic [31:0] a, input logic [3:0] c);
        strobe(up, a, c, 1'b0);
        chk("refused request", 32'(ans), 32'h0);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_idsel();
        logic [31:0] a;
        for (int d = 0; d < 16; d++) begin
            lat = d[0] ? 4'h6 : 4'h0;
            a = t1(sec, 5'(d), 3'h2, 6'h0a);
            xfer(1'b0, a, d[1] ? CMD_CFG_WR : CMD_CFG_RD, (32'h1 << (16 + d)) | (a & 32'h7fc),
                 d[1] ? CMD_CFG_WR : CMD_CFG_RD, 1'b0, 1'b0, d[2]);
        end
    endtask

    // devices without a select line still cross and end in master abort
    task automatic t_no_idsel();
        logic [31:0] a;
        for (int i = 0; i < 4; i++) begin
            lat = 4'h5;
            a = t1(sec, (i == 0) ? 5'h10 : (i == 1) ? 5'h1e : DEV_BCAST,
                   3'h5, (i == 3) ? 6'h0 : 6'h3);
            xfer(1'b0, a, (i == 3) ? CMD_CFG_RD : CMD_CFG_WR, a & 32'h7fc,
                 (i == 3) ? CMD_CFG_RD : CMD_CFG_WR, 1'b1, 1'b1, 1'b1);
        end
    endtask

    task automatic t_special_down();
        logic [31:0] a;
        lat = 4'h3;
        a = t1(sec, DEV_BCAST, FUNC_ALL, REG_SPECIAL);
        xfer(1'b0, a, CMD_CFG_WR, a, CMD_SPECIAL, 1'b0, 1'b0, 1'b1);
    endtask

    task automatic t_type1_down();
        lat = 4'h6;
        xfer(1'b0, t1(sec + 8'h1, 5'h3, 3'h1, 6'h4), CMD_CFG_RD, t1(sec + 8'h1, 5'h3, 3'h1, 6'h4),
             CMD_CFG_RD, 1'b0, 1'b0, 1'b0);
        lat = 4'h1;
        xfer(1'b0, t1(sub, 5'h1f, 3'h7, 6'h0), CMD_CFG_WR, t1(sub, 5'h1f, 3'h7, 6'h0),
             CMD_CFG_WR, 1'b0, 1'b0, 1'b1);
    endtask

    task automatic t_upstream();
        logic [31:0] a;
        lat = 4'h6;
        a = t1(8'h40, DEV_BCAST, FUNC_ALL, 6'h3);
        xfer(1'b1, a, CMD_CFG_WR, a, CMD_CFG_WR, 1'b0, 1'b0, 1'b0);
        lat = 4'h0;
        a = t1(8'h00, DEV_BCAST, FUNC_ALL, 6'h0);
        xfer(1'b1, a, CMD_CFG_WR, a, CMD_CFG_WR, 1'b0, 1'b0, 1'b1);
        a = t1(pri, DEV_BCAST, FUNC_ALL, 6'h0);
        xfer(1'b1, a, CMD_CFG_WR, a, CMD_SPECIAL, 1'b0, 1'b0, 1'b1);
    endtask

    task automatic t_refuse();
        refuse(1'b0, t1(sub + 8'h1, 5'h0, 3'h0, 6'h1), CMD_CFG_RD);
        refuse(1'b0, t1(pri, 5'h0, 3'h0, 6'h1), CMD_CFG_RD);
        refuse(1'b0, t1(sec, 5'h0, 3'h0, 6'h1) & 32'hffff_fffc, CMD_CFG_RD);
        refuse(1'b0, t1(sec, 5'h0, 3'h0, 6'h1) | 32'h2, CMD_CFG_WR);
        refuse(1'b0, t1(sec, 5'h0, 3'h0, 6'h1), 4'h6);
        refuse(1'b1, t1(8'h40, 5'h1, 3'h0, 6'h1) & 32'hffff_fffc, CMD_CFG_WR);
        refuse(1'b1, t1(sec, DEV_BCAST, FUNC_ALL, 6'h3), CMD_CFG_WR);
        refuse(1'b1, t1(sub, DEV_BCAST, FUNC_ALL, 6'h3), CMD_CFG_WR);
        refuse(1'b1, t1(8'h40, DEV_BCAST, FUNC_ALL, 6'h3), CMD_CFG_RD);
        refuse(1'b1, t1(8'h40, 5'h1e, FUNC_ALL, 6'h3), CMD_CFG_WR);
        refuse(1'b1, t1(8'h40, DEV_BCAST, 3'h6, 6'h3), CMD_CFG_WR);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        i_reset = 1'b1;
        p_valid = 1'b0;
        s_valid = 1'b0;
        req_addr = 32'h0;
        req_cmd = 4'h0;
        req_wd = 32'h0;
        req_multi = 1'b0;
        pri = 8'h01;
        sec = 8'h02;
        sub = 8'h05;
        lat = 4'h0;
        bad_count = 0;
        n_checks = 0;
        repeat (16) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        chk("reset state", {p_rdata[29:0], s_mst_valid, p_mst_valid}, 32'h0);
        i_reset = 1'b0;
        t_idsel();
        t_no_idsel();
        t_special_down();
        t_type1_down();
        t_upstream();
        t_refuse();
        final_report();
    end
endmodule // testbench
`default_nettype wire
